/* pkg/led_sink_pkg.sv */
package led_sink_pkg;

  localparam int NUM_UNITS = 3;
  localparam int CHANNELS = 8;
  localparam int CFG_W = 8;

  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STAT_A_OFFSET = 12'h004;
  localparam logic [11:0] STAT_B_OFFSET = 12'h008;
  localparam logic [11:0] STAT_C_OFFSET = 12'h00C;

  // status word fields
  localparam int STAT_LATCH_LSB = 0;
  localparam int STAT_CFG_LSB = 8;
  localparam int STAT_MODE_LSB = 16;
  localparam int STAT_SHIFT_LSB = 24;

  // control word: one sink enable per unit
  localparam int CTRL_EN_LSB = 0;
  localparam logic [2:0] CTRL_RESET = 3'h7;

  // default code standing for gain 127/128 and multiplier 1
  localparam logic [7:0] CFG_RESET = 8'hFF;

  // serial clock rises the gate must see high for a switch pulse
  localparam logic [1:0] GATE_PULSE_CLKS = 2'h1;
  // length of the switching phase in serial clock periods
  localparam logic [1:0] SWITCH_CLKS = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SWITCH = 2'b01,
    MODE_ADJUST = 2'b10
  } mode_t;

  localparam logic [1:0] DEC_CTRL = 2'h0;
  localparam logic [1:0] DEC_STAT = 2'h1;
  localparam logic [1:0] DEC_NONE = 2'h2;

endpackage

/* design/serial_clock_edge.sv */
`timescale 1ns/1ps
module serial_clock_edge (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // sampled serial clock level
  input wire logic level,
  // one pclk pulse on a rising edge
  output logic rise
);

  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t state_q;
  edge_state_t state_d;

  always_comb begin
    state_d = state_q;
    state_d.prev = level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rise = level & ~state_q.prev;

endmodule

/* design/gate_pulse_detect.sv */
`timescale 1ns/1ps
module gate_pulse_detect (
  // system
  input wire logic pclk,
  input wire logic presetn,
  // unit pins
  input wire logic sclk_rise,
  input wire logic blank_trigger_n,
  // one pclk pulse after a valid switch pulse ends
  output logic phase_change_trigger
);

  typedef struct packed {
    logic gate;
    logic [1:0] rises;
    logic trig;
  } gate_state_t;

  gate_state_t state_q;
  gate_state_t state_d;

  always_comb begin
    state_d = state_q;
    state_d.gate = blank_trigger_n;
    state_d.trig = 1'b0;
    if (blank_trigger_n && !state_q.gate) begin
      state_d.rises = sclk_rise ? 2'h1 : 2'h0;
    end else if (blank_trigger_n) begin
      // saturate so long blanking never counts as a pulse
      if (sclk_rise && state_q.rises != 2'h3) begin
        state_d.rises = state_q.rises + 2'h1;
      end
    end else if (state_q.gate) begin
      state_d.trig = (state_q.rises == led_sink_pkg::GATE_PULSE_CLKS);
      state_d.rises = 2'h3;
    end
  end

  // idle high after reset with a saturated count: no spurious switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '{gate: 1'b1, rises: 2'h3, trig: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign phase_change_trigger = state_q.trig;

endmodule

/* design/led_sink_serial_control.sv */
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module led_sink_serial_control (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins, one bit per unit
  input wire logic [2:0] serial_in,
  input wire logic [2:0] serial_clk,
  input wire logic [2:0] latch_strobe,
  input wire logic [2:0] blank_trigger_n,
  output logic [2:0] serial_out,
  // sinks, high means channel conducts
  output logic [2:0][7:0] sink_channel,
  // configuration code to the current-setting circuitry
  output logic [2:0][7:0] config_code
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    led_sink_pkg::mode_t mode;
    logic [1:0] sw_cnt;
    logic [7:0] shift;
    logic [7:0] out_latch;
    logic [7:0] cfg;
    logic [7:0] sink;
    logic sout;
  } unit_t;

  typedef struct packed {
    unit_t [2:0] u;
    logic [2:0] sink_en;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [2:0] sclk_rise;
  logic [2:0] phase_trig;

  ////////////////////////////////////////////////////////////////////////
  // per-unit edge and pulse detection

  for (genvar g = 0; g < led_sink_pkg::NUM_UNITS; g++) begin : g_unit
    serial_clock_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .level(serial_clk[g]),
      .rise(sclk_rise[g])
    );
    gate_pulse_detect u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .sclk_rise(sclk_rise[g]),
      .blank_trigger_n(blank_trigger_n[g]),
      .phase_change_trigger(phase_trig[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] decode(input logic [11:0] addr);
    logic [1:0] kind;
    kind = led_sink_pkg::DEC_NONE;
    if (addr == led_sink_pkg::CTRL_OFFSET) begin
      kind = led_sink_pkg::DEC_CTRL;
    end else if (addr == led_sink_pkg::STAT_A_OFFSET ||
                 addr == led_sink_pkg::STAT_B_OFFSET ||
                 addr == led_sink_pkg::STAT_C_OFFSET) begin
      kind = led_sink_pkg::DEC_STAT;
    end
    return kind;
  endfunction

  function automatic logic [31:0] status_word(input unit_t u);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[led_sink_pkg::STAT_LATCH_LSB +: 8] = u.out_latch;
    w[led_sink_pkg::STAT_CFG_LSB +: 8] = u.cfg;
    w[led_sink_pkg::STAT_MODE_LSB +: 2] = u.mode;
    w[led_sink_pkg::STAT_SHIFT_LSB +: 8] = u.shift;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [1:0] kind;
    logic setup;
    logic access;
    kind = decode(paddr);
    setup = psel & ~penable;
    access = psel & penable & state_q.ready;
    state_d = state_q;

    for (int i = 0; i < led_sink_pkg::NUM_UNITS; i++) begin
      // shifting runs in every phase
      if (sclk_rise[i]) begin
        state_d.u[i].shift = {state_q.u[i].shift[6:0], serial_in[i]};
      end
      case (state_q.u[i].mode)
        led_sink_pkg::MODE_NORMAL: begin
          if (latch_strobe[i]) begin
            state_d.u[i].out_latch = state_d.u[i].shift;
          end
        end
        led_sink_pkg::MODE_SWITCH: begin
          // strobe only selects the mode here, no latch loads
          if (sclk_rise[i]) begin
            state_d.u[i].sw_cnt = state_q.u[i].sw_cnt + 2'h1;
            if (state_q.u[i].sw_cnt + 2'h1 == led_sink_pkg::SWITCH_CLKS) begin
              state_d.u[i].mode = latch_strobe[i] ? led_sink_pkg::MODE_ADJUST
                                                  : led_sink_pkg::MODE_NORMAL;
            end
          end
        end
        led_sink_pkg::MODE_ADJUST: begin
          // only path that alters the config code
          if (latch_strobe[i]) begin
            state_d.u[i].cfg = state_d.u[i].shift;
          end
        end
        default: begin
          state_d.u[i].mode = led_sink_pkg::MODE_NORMAL;
        end
      endcase
      // a fresh pulse restarts switching from any phase
      if (phase_trig[i]) begin
        state_d.u[i].mode = led_sink_pkg::MODE_SWITCH;
        state_d.u[i].sw_cnt = 2'h0;
      end
      // gate blanks every channel whatever the phase
      state_d.u[i].sink = state_d.u[i].out_latch &
                          {8{~blank_trigger_n[i] & state_q.sink_en[i]}};
      state_d.u[i].sout = state_d.u[i].shift[7];
    end

    // zero-wait apb: answer is prepared in setup, given in access
    state_d.ready = setup;
    state_d.err = setup & (kind == led_sink_pkg::DEC_NONE);
    state_d.rdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        led_sink_pkg::CTRL_OFFSET: begin
          state_d.rdata[led_sink_pkg::CTRL_EN_LSB +: 3] = state_q.sink_en;
        end
        led_sink_pkg::STAT_A_OFFSET: begin
          state_d.rdata = status_word(state_q.u[0]);
        end
        led_sink_pkg::STAT_B_OFFSET: begin
          state_d.rdata = status_word(state_q.u[1]);
        end
        led_sink_pkg::STAT_C_OFFSET: begin
          state_d.rdata = status_word(state_q.u[2]);
        end
        default: begin
          state_d.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (access && pwrite && decode(paddr) == led_sink_pkg::DEC_CTRL) begin
      state_d.sink_en = pwdata[led_sink_pkg::CTRL_EN_LSB +: 3];
    end
    if (access) begin
      state_d.ready = 1'b0;
      state_d.err = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < led_sink_pkg::NUM_UNITS; i++) begin
        state_q.u[i].mode <= led_sink_pkg::MODE_NORMAL;
        state_q.u[i].sw_cnt <= 2'h0;
        state_q.u[i].shift <= 8'h00;
        state_q.u[i].out_latch <= 8'h00;
        state_q.u[i].cfg <= led_sink_pkg::CFG_RESET;
        state_q.u[i].sink <= 8'h00;
        state_q.u[i].sout <= 1'b0;
      end
      state_q.sink_en <= led_sink_pkg::CTRL_RESET;
      state_q.rdata <= 32'h0000_0000;
      state_q.ready <= 1'b0;
      state_q.err <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    for (int i = 0; i < led_sink_pkg::NUM_UNITS; i++) begin
      sink_channel[i] = state_q.u[i].sink;
      // one code per unit, not per channel, and never decoded here
      config_code[i] = state_q.u[i].cfg;
      serial_out[i] = state_q.u[i].sout;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.err;

endmodule

/* dv/led_sink_serial_control_asserts.sv */
`timescale 1ns/1ps
module led_sink_serial_control_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // unit pins
  input wire logic [2:0] serial_clk,
  input wire logic [2:0] latch_strobe,
  input wire logic [2:0] blank_trigger_n,
  input wire logic [2:0] serial_out,
  input wire logic [2:0][7:0] sink_channel,
  input wire logic [2:0][7:0] config_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rst; $rose(presetn) |-> config_code == {3{8'hFF}}; endproperty
  a_rst: assert property (p_rst) else $error("config not default");
  property p_blank; &blank_trigger_n |=> sink_channel == '0; endproperty
  a_blank: assert property (p_blank) else $error("sink while blanked");
  property p_gate; |sink_channel[0] |-> !$past(blank_trigger_n[0]); endproperty
  a_gate: assert property (p_gate) else $error("sink with gate high");
  // output may move only just after a serial clock rise
  property p_sout; $changed(serial_out[0]) |-> $past(serial_clk[0]) || $past(serial_clk[0], 2);
  endproperty
  a_sout: assert property (p_sout) else $error("serial out moved");
  property p_cfg0; $changed(config_code[0]) |->
    $past(latch_strobe[0]) || $past(latch_strobe[0], 2);
  endproperty
  a_cfg0: assert property (p_cfg0) else $error("config changed alone");
  property p_cfg1; $changed(config_code[1]) |->
    $past(latch_strobe[1]) || $past(latch_strobe[1], 2);
  endproperty
  a_cfg1: assert property (p_cfg1) else $error("unit b config changed");
endmodule

bind led_sink_serial_control led_sink_serial_control_asserts u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .serial_clk(serial_clk), .latch_strobe(latch_strobe), .blank_trigger_n(blank_trigger_n),
  .serial_out(serial_out), .sink_channel(sink_channel), .config_code(config_code));

/* dv/display_ctl.sv */
`timescale 1ns/1ps
module display_ctl (
  // clock
  input wire logic pclk,
  // serial pins per unit
  output logic [2:0] ser_data,
  output logic [2:0] sck,
  output logic [2:0] stb,
  output logic [2:0] gate_n
);
  // gate idles high as its pull-up would; serial clock stands low between frames
  initial begin
    ser_data = 3'h0;
    sck = 3'h0;
    stb = 3'h0;
    gate_n = 3'h7;
  end
  task automatic wt(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic gate(logic [2:0] g);
    gate_n <= g;
  endtask
  // data flips once the bit is taken so a stale bit never passes
  task automatic rise(int u, logic b);
    ser_data[u] <= b;
    sck[u] <= 1'b1;
    wt(2);
    sck[u] <= 1'b0;
    ser_data[u] <= ~b;
    wt(2);
  endtask
  task automatic send(int u, logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      rise(u, d[i]);
    end
  endtask
  task automatic pulse(int u);
    stb[u] <= 1'b1;
    wt(2);
    stb[u] <= 1'b0;
    wt(2);
  endtask
  task automatic mode_sw(int u, logic sel);
    gate_n[u] <= 1'b1;
    rise(u, 1'b0);
    gate_n[u] <= 1'b0;
    wt(3);
    stb[u] <= sel;
    rise(u, 1'b0);
    // known bit on the closing rise keeps the shift contents predictable
    ser_data[u] <= 1'b0;
    sck[u] <= 1'b1;
    wt(1);
    stb[u] <= 1'b0;
    wt(1);
    sck[u] <= 1'b0;
    wt(2);
  endtask
endmodule

/* dv/led_sink_serial_control_test.sv */
`timescale 1ns/1ps
module led_sink_serial_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] ser_data, sck, stb, gate_n, sout;
  logic [2:0][7:0] sink, cfg;
  int miscompares;
  int cmp_count;
  display_ctl ctl (.pclk(pclk), .ser_data(ser_data), .sck(sck), .stb(stb), .gate_n(gate_n));
  led_sink_serial_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in(ser_data), .serial_clk(sck),
    .latch_strobe(stb), .blank_trigger_n(gate_n), .serial_out(sout), .sink_channel(sink),
    .config_code(cfg));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk("cfg", cfg, {3{8'hFF}});
    apb(1'b0, led_sink_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl", rd, 32'h7);
    apb(1'b0, led_sink_pkg::STAT_A_OFFSET, 32'h0);
    chk("stat", rd, 32'h0000FF00);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", err, 1'b1);
  endtask
  task automatic s_normal();
    ctl.send(0, 8'hA5);
    chk("sout", sout[0], 1'b1);
    ctl.pulse(0);
    chk("sink", sink[0], 8'hA5);
    ctl.send(0, 8'h3C);
    chk("hold", sink[0], 8'hA5);
    chk("sink_b", sink[1], 8'h00);
    ctl.gate(3'h7);
    ctl.wt(3);
    chk("blank", sink[0], 8'h00);
    ctl.gate(3'h0);
    apb(1'b1, led_sink_pkg::CTRL_OFFSET, 32'h6);
    apb(1'b0, led_sink_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl", rd, 32'h6);
    chk("off", sink[0], 8'h00);
    apb(1'b1, led_sink_pkg::CTRL_OFFSET, 32'h7);
    ctl.wt(3);
    chk("back", sink[0], 8'hA5);
  endtask
  task automatic s_adjust();
    ctl.mode_sw(0, 1'b1);
    apb(1'b0, led_sink_pkg::STAT_A_OFFSET, 32'h0);
    chk("stat", rd, 32'hE002FFA5);
    ctl.send(0, 8'h5A);
    ctl.pulse(0);
    chk("cfg_a", cfg[0], 8'h5A);
    chk("cfg_b", cfg[1], 8'hFF);
    chk("sink", sink[0], 8'hA5);
    ctl.mode_sw(0, 1'b0);
    ctl.send(0, 8'h81);
    ctl.pulse(0);
    chk("cfg_h", cfg[0], 8'h5A);
    chk("sink_n", sink[0], 8'h81);
  endtask
  task automatic s_units();
    ctl.send(1, 8'hC3);
    ctl.send(2, 8'h96);
    ctl.pulse(2);
    chk("sink_c", sink[2], 8'h96);
    chk("sink_b0", sink[1], 8'h00);
    chk("sout_b", sout[1], 1'b1);
    chk("sout_c", sout[2], 1'b1);
    ctl.mode_sw(1, 1'b1);
    ctl.send(1, 8'h24);
    ctl.pulse(1);
    chk("cfg_b1", cfg[1], 8'h24);
    chk("cfg_c", cfg[2], 8'hFF);
    chk("sink_b1", sink[1], 8'h00);
    apb(1'b0, led_sink_pkg::STAT_B_OFFSET, 32'h0);
    chk("stat_b", rd, 32'h24022400);
    // two serial clocks under the gate is plain blanking, not a switch pulse
    ctl.gate(3'h4);
    ctl.rise(2, 1'b0);
    ctl.rise(2, 1'b0);
    chk("dark_c", sink[2], 8'h00);
    chk("lit_a", sink[0], 8'h81);
    ctl.gate(3'h0);
    ctl.wt(3);
    apb(1'b0, led_sink_pkg::STAT_C_OFFSET, 32'h0);
    chk("stat_c", rd, 32'h5800FF96);
    chk("sink_c1", sink[2], 8'h96);
    // status words are read only; zero data would blank all if misdecoded
    apb(1'b1, led_sink_pkg::STAT_A_OFFSET, 32'h0);
    chk("st_err", err, 1'b0);
    apb(1'b0, led_sink_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl_k", rd, 32'h7);
    apb(1'b0, led_sink_pkg::STAT_A_OFFSET, 32'h0);
    chk("stat_a", rd, 32'h81005A81);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    cmp_count = 0;
    ctl.wt(16);
    presetn <= 1'b1;
    ctl.gate(3'h0);
    s_reset();
    s_normal();
    s_adjust();
    s_units();
    finish_test();
  end
endmodule
